//--- can_master_model.sv
`timescale 1ns/1ns
module can_master_model import psu_can_pkg::*; (
	input wire logic clk, // system clock
	input wire logic [1:0] addr_strap, // unit address
	output logic rx_valid, // frame offered
	input wire logic rx_ready, // frame taken
	output logic [28:0] rx_id, // identifier
	output logic [3:0] rx_dlc, // length
	output logic [31:0] rx_data, // payload
	input wire logic tx_valid, // reply waiting
	output logic tx_ready, // reply taken
	input wire logic [28:0] tx_id, // reply identifier
	input wire logic [3:0] tx_dlc, // reply length
	input wire logic [31:0] tx_data // reply payload
);
	logic [28:0] got_id;
	logic [3:0] got_dlc;
	logic [31:0] got_data;
	int got_n = 0;
	initial rx_valid = 1'b0;
	// stalls about one cycle in four, so replies are taken both promptly and late
	always @(negedge clk) tx_ready <= ($urandom & 3) != 0;
	always @(posedge clk) if (tx_valid === 1'b1 && tx_ready) begin
		got_id <= tx_id;
		got_dlc <= tx_dlc;
		got_data <= tx_data;
		got_n <= got_n + 1;
	end
	task automatic send(input logic [3:0] l, input logic [15:0] c, input logic [15:0] d);
		@(negedge clk);
		rx_id = ID_TO_UNIT_BASE | {27'h0, addr_strap};
		rx_dlc = l;
		rx_data = {d, c};
		rx_valid = 1'b1;
		@(posedge clk);
		while (rx_ready !== 1'b1) @(posedge clk);
		@(negedge clk);
		rx_valid = 1'b0;
		// released id and data lines show the inverse so a stale sample cannot pass
		rx_data = ~rx_data;
		rx_id = ~rx_id;
	endtask
endmodule // can_master_model

//--- interval_timer.sv
`timescale 1ns/1ns
module interval_timer #(
	parameter int PERIOD = 4
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset, active low
	input wire logic tick, // time base pulse
	input wire logic restart, // clear the count
	input wire logic run, // count ticks while high
	output logic expire // one-cycle pulse after PERIOD ticks
);
	localparam int W = $clog2(PERIOD + 1);
	localparam logic [W-1:0] LAST = W'(PERIOD - 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic exp_reg;
	logic exp_next;
	if (PERIOD < 2) begin : g_chk
		$error("interval_timer needs PERIOD of at least 2");
	end
	always_comb begin
		cnt_next = cnt_reg;
		exp_next = 1'b0;
		if (restart) begin
			cnt_next = '0;
		end else if (run && tick) begin
			if (cnt_reg == LAST) begin
				cnt_next = '0;
				exp_next = 1'b1;
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			exp_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			exp_reg <= exp_next;
		end
	end
	assign expire = exp_reg;
endmodule // interval_timer

//--- ms_tick.sv
`timescale 1ns/1ns
module ms_tick import psu_can_pkg::*; #(
	parameter int CYCLES = TICK_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic arst_n, // async reset, active low
	output logic tick // one-cycle pulse each period
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;
	if (CYCLES < 2) begin : g_chk
		$error("ms_tick needs CYCLES of at least 2");
	end
	always_comb begin
		tick_next = (cnt_reg == LAST);
		cnt_next = tick_next ? '0 : cnt_reg + 1'b1;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end
	assign tick = tick_reg;
endmodule // ms_tick

//--- psu_can_pkg.sv
package psu_can_pkg;
	// command codes, carried low byte first in data bytes 0 and 1
	localparam logic [15:0] CMD_OPERATION = 16'h0000;
	localparam logic [15:0] CMD_VOUT_SET = 16'h0020;
	localparam logic [15:0] CMD_SYSTEM_STATE = 16'h00C1;
	localparam logic [15:0] CMD_POWER_CONFIG = 16'h00C2;
	localparam logic [15:0] CMD_BAT_FUNC = 16'h00E0;
	localparam logic [15:0] CMD_BUFFER_TIME = 16'h00E4;
	localparam logic [15:0] CMD_DELAY_TIME = 16'h00E7;
	localparam logic [15:0] CMD_RESTART_TIME = 16'h00E8;
	// frame identifiers, device address in the low two bits
	localparam logic [28:0] ID_TO_UNIT_BASE = 29'h000C0100;
	localparam logic [28:0] ID_TO_MASTER_BASE = 29'h000C0000;
	localparam logic [3:0] DLC_WRITE = 4'h4;
	localparam logic [3:0] DLC_READ = 4'h2;
	localparam logic [3:0] DLC_REPLY_BYTE = 4'h3;
	localparam logic [3:0] DLC_REPLY_WORD = 4'h4;
	// system_state bit positions
	localparam int ST_OUT_GOOD = 1;
	localparam int ST_INIT_DONE = 5;
	localparam int ST_NVM_ERR = 6;
	localparam int ST_BAT_MODE = 7;
	// power_config fields
	localparam int CFG_START_LSB = 1;
	localparam int CFG_POLICY_LSB = 8;
	localparam int CFG_SAVE_OFF = 10;
	localparam logic [15:0] CFG_RESET = 16'h0002;
	localparam logic [1:0] START_OFF = 2'b00;
	localparam logic [1:0] START_ON = 2'b01;
	localparam logic [1:0] START_PREV = 2'b10;
	localparam logic [1:0] START_RSV = 2'b11;
	localparam logic [1:0] POLICY_NOW = 2'b00;
	localparam logic [1:0] POLICY_1MIN = 2'b01;
	localparam logic [1:0] POLICY_10MIN = 2'b10;
	localparam logic [1:0] POLICY_RSV = 2'b11;
	// battery_function_enables bits
	localparam int BF_SELF_TEST = 0;
	localparam int BF_BUTTON_OFF = 1;
	localparam int BF_BUFFER = 2;
	localparam int BF_WAKE = 3;
	localparam int BF_DELAY = 4;
	localparam int BF_RESTART = 5;
	localparam logic [15:0] BF_MASK = 16'h003F;
	localparam logic [15:0] BF_RESET = 16'h0009;
	localparam logic [15:0] VOUT_RESET = 16'h0000;
	// timing: a millisecond tick drives every long timer
	localparam int CLK_HZ = 50000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int POWER_HOLD_S = 5;
	localparam int WAKE_REPEAT_MIN = 5;
	localparam int SELF_TEST_S = 30;
	localparam int QUIET_SHORT_MIN = 1;
	localparam int QUIET_LONG_MIN = 10;
	localparam int POWER_HOLD_MS = POWER_HOLD_S * 1000;
	localparam int WAKE_REPEAT_MS = WAKE_REPEAT_MIN * 60000;
	localparam int SELF_TEST_MS = SELF_TEST_S * 1000;
	localparam int QUIET_SHORT_MS = QUIET_SHORT_MIN * 60000;
	localparam int QUIET_LONG_MS = QUIET_LONG_MIN * 60000;
	localparam logic [4:0] INIT_LAST = 5'h0F;
	// output level targets in percent of rated
	localparam logic [7:0] PCT_RATED = 8'h64;
	localparam logic [7:0] PCT_LOW = 8'h46;
	localparam logic [7:0] PCT_HIGH = 8'h82;
	typedef enum logic [2:0] {
		WK_RATED = 3'b000,
		WK_DROP = 3'b001,
		WK_RAMP = 3'b010,
		WK_HIGH = 3'b011,
		WK_RETURN = 3'b100,
		WK_CHARGE = 3'b101
	} wake_state_e;
endpackage

//--- psu_can_status_config.sv
// How it works
// - status bit 1 shows output voltage good, 0 too low
// - status bit 5 is 0 during initialization, 1 afterwards
// - status bit 6 sets on failed memory access, clears on success
// - status bit 7 is 0 charging, 1 running from battery
// - unsupported status bits and status high byte always read zero
// - start-up field picks off, on or previous; 11 reserved
// - save policy 00 commits every change to memory at once
// - policy 01 commits after one quiet minute, 10 after ten
// - save-disable bit set blocks every memory commit
// - battery bit 0 enables periodic self-test, default on
// - battery bit 1 enables shutdown of button-forced start, default off
// - battery bit 2 enables timed buffering, interval at code E4
// - battery bit 3 enables periodic wake-up, default on
// - battery bit 4 enables delayed shutdown, delay at code E7
// - battery bit 5 enables restart time, time at code E8
// - power-on: rated, after 5 s 70%, ramp, no battery 130%
// - wake-up repeats every 5 minutes; enable gates repeats only
// - self-test every 30 s when battery and current qualify
// - reply to master echoes code plus value; operation gives length 3
// - voltage setpoint is unsigned hundredths of a volt, low byte first
// - identifiers carry the strapped two-bit device address
`timescale 1ns/1ns
module psu_can_status_config import psu_can_pkg::*; #(
	parameter int TICK_CYC = TICK_CYCLES,
	parameter int HOLD_MS = POWER_HOLD_MS,
	parameter int WAKE_MS = WAKE_REPEAT_MS,
	parameter int TEST_MS = SELF_TEST_MS,
	parameter int QUIET1_MS = QUIET_SHORT_MS,
	parameter int QUIET10_MS = QUIET_LONG_MS
) (
	input wire logic clk, // 50 MHz system clock
	input wire logic arst_n, // async reset, active low
	input wire logic [1:0] addr_strap, // device address pins
	input wire logic output_voltage_good, // pin, output level ok
	input wire logic charge_or_battery_mode, // pin, 1 on battery
	input wire logic battery_present, // pin, battery detected
	input wire logic level_reached, // pin, output reached its target
	input wire logic vbat_ge_rated, // pin, battery at least rated
	input wire logic charge_current_ok, // pin, charge current at least 5%
	input wire logic battery_low, // pin, battery under low limit
	input wire logic nvm_done, // memory access succeeded, pulse
	input wire logic nvm_fail, // memory access failed, pulse
	input wire logic prev_operation, // stored operation setting
	input wire logic rx_valid, // received frame present
	output logic rx_ready, // frame may be taken
	input wire logic [28:0] rx_id, // extended identifier
	input wire logic [3:0] rx_dlc, // data length
	input wire logic [31:0] rx_data, // bytes 0..3, byte 0 low
	output logic tx_valid, // reply frame waiting
	input wire logic tx_ready, // reply taken
	output logic [28:0] tx_id, // reply identifier
	output logic [3:0] tx_dlc, // reply length
	output logic [31:0] tx_data, // reply bytes 0..3
	output logic init_done, // initialization finished
	output logic output_on, // operation setting
	output logic [15:0] vout_setpoint, // 0.01 V units
	output logic [5:0] battery_functions, // enable bits
	output logic [15:0] buffer_time, // buffering interval
	output logic [15:0] delay_time, // battery-mode shutdown delay
	output logic [15:0] restart_time, // battery-mode restart time
	output logic [7:0] vout_target_pct, // output target, percent rated
	output logic vout_track_battery, // ramp output toward battery
	output logic charging_active, // wake-up over, charging
	output logic battery_test_pulse, // self-test started
	output logic battery_abnormal, // last self-test failed
	output logic nvm_commit // write parameters to memory, pulse
);
	logic [8:0] sync1_reg;
	logic [8:0] sync2_reg;
	logic [1:0] s_addr;
	logic s_good, s_bat, s_present, s_reached, s_vbat, s_ichg, s_low;
	logic tick;
	logic [4:0] init_cnt_reg, init_cnt_next;
	logic init_done_reg, init_done_next;
	logic [1:0] addr_reg, addr_next;
	logic op_reg, op_next;
	logic [15:0] vout_reg, vout_next, cfg_reg, cfg_next, bf_reg, bf_next;
	logic [15:0] tbuf_reg, tbuf_next, tdly_reg, tdly_next, trst_reg, trst_next;
	logic txv_reg, txv_next;
	logic [28:0] txid_reg, txid_next;
	logic [3:0] txdlc_reg, txdlc_next;
	logic [31:0] txd_reg, txd_next;
	logic change;
	logic [15:0] status_word;
	logic [15:0] code, wval, rval;
	logic hit;
	logic pend_reg, pend_next, commit_reg, commit_next, err_reg, err_next;
	logic q1_exp, q10_exp, q_exp;
	wake_state_e wk_reg, wk_next;
	logic hold_exp, wake_exp, test_exp, test_run;
	logic tp_reg, tp_next, abn_reg, abn_next;
	wire logic [1:0] policy = cfg_reg[CFG_POLICY_LSB +: 2];
	wire logic save_off = cfg_reg[CFG_SAVE_OFF];

	// pins cross into the clock domain through two flops
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {addr_strap, output_voltage_good, charge_or_battery_mode,
				battery_present, level_reached, vbat_ge_rated, charge_current_ok,
				battery_low};
			sync2_reg <= sync1_reg;
		end
	end
	assign {s_addr, s_good, s_bat, s_present, s_reached, s_vbat, s_ichg, s_low} = sync2_reg;

	ms_tick #(.CYCLES(TICK_CYC)) u_tick (.clk(clk), .arst_n(arst_n), .tick(tick));

	// straps are caught at the end of initialization, well after release
	always_comb begin
		init_cnt_next = init_cnt_reg;
		init_done_next = init_done_reg;
		addr_next = addr_reg;
		if (!init_done_reg) begin
			init_cnt_next = init_cnt_reg + 1'b1;
			if (init_cnt_reg == INIT_LAST) begin
				init_done_next = 1'b1;
				addr_next = s_addr;
			end
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			init_cnt_reg <= '0;
			init_done_reg <= 1'b0;
			addr_reg <= 2'b00;
		end else begin
			init_cnt_reg <= init_cnt_next;
			init_done_reg <= init_done_next;
			addr_reg <= addr_next;
		end
	end

	always_comb begin
		status_word = 16'h0000;
		status_word[ST_OUT_GOOD] = s_good;
		status_word[ST_INIT_DONE] = init_done_reg;
		status_word[ST_NVM_ERR] = err_reg;
		status_word[ST_BAT_MODE] = s_bat;
	end

	// a pending reply stalls reception so no waiting reply is overwritten before it is taken
	assign rx_ready = !txv_reg;
	assign code = rx_data[15:0];
	assign wval = rx_data[31:16];
	assign hit = rx_valid && rx_ready && init_done_reg
		&& rx_id == (ID_TO_UNIT_BASE | {27'h0, addr_reg});

	always_comb begin
		case (code)
			CMD_OPERATION: rval = {15'h0000, op_reg};
			CMD_VOUT_SET: rval = vout_reg;
			CMD_SYSTEM_STATE: rval = status_word;
			CMD_POWER_CONFIG: rval = cfg_reg;
			CMD_BAT_FUNC: rval = bf_reg;
			CMD_BUFFER_TIME: rval = tbuf_reg;
			CMD_DELAY_TIME: rval = tdly_reg;
			CMD_RESTART_TIME: rval = trst_reg;
			default: rval = 16'h0000;
		endcase
	end

	always_comb begin
		op_next = op_reg;
		vout_next = vout_reg;
		cfg_next = cfg_reg;
		bf_next = bf_reg;
		tbuf_next = tbuf_reg;
		tdly_next = tdly_reg;
		trst_next = trst_reg;
		txv_next = txv_reg && !tx_ready;
		txid_next = txid_reg;
		txdlc_next = txdlc_reg;
		txd_next = txd_reg;
		change = 1'b0;
		if (!init_done_reg && init_cnt_reg == INIT_LAST) begin
			case (cfg_reg[CFG_START_LSB +: 2])
				START_OFF: op_next = 1'b0;
				START_ON: op_next = 1'b1;
				START_PREV: op_next = prev_operation;
				default: op_next = op_reg;
			endcase
		end
		if (hit && rx_dlc == DLC_WRITE) begin
			change = 1'b1;
			case (code)
				CMD_OPERATION: begin
					if (wval[15:1] == 15'h0000) begin
						op_next = wval[0];
					end else begin
						change = 1'b0;
					end
				end
				CMD_VOUT_SET: vout_next = wval;
				CMD_POWER_CONFIG: begin
					// reserved encodings keep the old field, other fields still land
					if (wval[CFG_START_LSB +: 2] != START_RSV) begin
						cfg_next[CFG_START_LSB +: 2] = wval[CFG_START_LSB +: 2];
					end
					if (wval[CFG_POLICY_LSB +: 2] != POLICY_RSV) begin
						cfg_next[CFG_POLICY_LSB +: 2] = wval[CFG_POLICY_LSB +: 2];
					end
					cfg_next[CFG_SAVE_OFF] = wval[CFG_SAVE_OFF];
				end
				CMD_BAT_FUNC: bf_next = wval & BF_MASK;
				CMD_BUFFER_TIME: tbuf_next = wval;
				CMD_DELAY_TIME: tdly_next = wval;
				CMD_RESTART_TIME: trst_next = wval;
				default: change = 1'b0;
			endcase
		end else if (hit && rx_dlc == DLC_READ) begin
			case (code)
				CMD_OPERATION, CMD_VOUT_SET, CMD_SYSTEM_STATE, CMD_POWER_CONFIG,
				CMD_BAT_FUNC, CMD_BUFFER_TIME, CMD_DELAY_TIME, CMD_RESTART_TIME: begin
					txv_next = 1'b1;
					txid_next = ID_TO_MASTER_BASE | {27'h0, addr_reg};
					txd_next = {rval, code};
					txdlc_next = (code == CMD_OPERATION) ? DLC_REPLY_BYTE : DLC_REPLY_WORD;
					if (code == CMD_OPERATION) begin
						txd_next[31:24] = 8'h00;
					end
				end
				default: txv_next = txv_reg && !tx_ready;
			endcase
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			op_reg <= 1'b0;
			vout_reg <= VOUT_RESET;
			cfg_reg <= CFG_RESET;
			bf_reg <= BF_RESET;
			tbuf_reg <= 16'h0000;
			tdly_reg <= 16'h0000;
			trst_reg <= 16'h0000;
			txv_reg <= 1'b0;
			txid_reg <= '0;
			txdlc_reg <= 4'h0;
			txd_reg <= '0;
		end else begin
			op_reg <= op_next;
			vout_reg <= vout_next;
			cfg_reg <= cfg_next;
			bf_reg <= bf_next;
			tbuf_reg <= tbuf_next;
			tdly_reg <= tdly_next;
			trst_reg <= trst_next;
			txv_reg <= txv_next;
			txid_reg <= txid_next;
			txdlc_reg <= txdlc_next;
			txd_reg <= txd_next;
		end
	end

	// quiet-period timers; a change clears the count of both
	interval_timer #(.PERIOD(QUIET1_MS)) u_q1 (.clk(clk), .arst_n(arst_n), .tick(tick),
		.restart(change), .run(pend_reg && policy == POLICY_1MIN), .expire(q1_exp));
	interval_timer #(.PERIOD(QUIET10_MS)) u_q10 (.clk(clk), .arst_n(arst_n), .tick(tick),
		.restart(change), .run(pend_reg && policy == POLICY_10MIN), .expire(q10_exp));
	assign q_exp = (q1_exp && policy == POLICY_1MIN) || (q10_exp && policy == POLICY_10MIN);

	always_comb begin
		commit_next = 1'b0;
		pend_next = pend_reg;
		if (change && policy == POLICY_NOW) begin
			commit_next = !save_off;
			pend_next = 1'b0;
		end else if (change) begin
			pend_next = !save_off;
		end else if (q_exp && pend_reg) begin
			commit_next = !save_off;
			pend_next = 1'b0;
		end
		if (save_off) begin
			pend_next = 1'b0;
		end
		// a failure in the same cycle as a success wins
		err_next = nvm_fail ? 1'b1 : (nvm_done ? 1'b0 : err_reg);
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg <= 1'b0;
			commit_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			commit_reg <= commit_next;
			err_reg <= err_next;
		end
	end

	interval_timer #(.PERIOD(HOLD_MS)) u_hold (.clk(clk), .arst_n(arst_n), .tick(tick),
		.restart(wk_reg != WK_RATED), .run(init_done_reg), .expire(hold_exp));
	interval_timer #(.PERIOD(WAKE_MS)) u_wake (.clk(clk), .arst_n(arst_n), .tick(tick),
		.restart(!init_done_reg), .run(1'b1), .expire(wake_exp));

	always_comb begin
		wk_next = wk_reg;
		case (wk_reg)
			WK_RATED: if (hold_exp) wk_next = WK_DROP;
			WK_DROP: wk_next = WK_RAMP;
			WK_RAMP: begin
				if (!s_present) begin
					wk_next = WK_HIGH;
				end else if (s_reached) begin
					wk_next = WK_CHARGE;
				end
			end
			WK_HIGH: if (s_reached) wk_next = WK_RETURN;
			WK_RETURN: if (s_reached) wk_next = WK_CHARGE;
			WK_CHARGE: if (wake_exp && bf_reg[BF_WAKE]) wk_next = WK_DROP;
			default: wk_next = WK_RATED;
		endcase
	end

	// self-test only while charging, so it never disturbs a wake-up ramp
	assign test_run = wk_reg == WK_CHARGE && bf_reg[BF_SELF_TEST] && s_vbat && s_ichg;
	interval_timer #(.PERIOD(TEST_MS)) u_test (.clk(clk), .arst_n(arst_n), .tick(tick),
		.restart(!test_run), .run(test_run), .expire(test_exp));

	always_comb begin
		tp_next = test_exp && test_run;
		abn_next = tp_reg ? s_low : abn_reg;
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wk_reg <= WK_RATED;
			tp_reg <= 1'b0;
			abn_reg <= 1'b0;
		end else begin
			wk_reg <= wk_next;
			tp_reg <= tp_next;
			abn_reg <= abn_next;
		end
	end

	assign vout_target_pct = (wk_reg == WK_DROP) ? PCT_LOW
		: (wk_reg == WK_HIGH) ? PCT_HIGH : PCT_RATED;
	assign vout_track_battery = wk_reg == WK_RAMP;
	assign charging_active = wk_reg == WK_CHARGE;
	assign battery_test_pulse = tp_reg;
	assign battery_abnormal = abn_reg;
	assign nvm_commit = commit_reg;
	assign tx_valid = txv_reg;
	assign tx_id = txid_reg;
	assign tx_dlc = txdlc_reg;
	assign tx_data = txd_reg;
	assign init_done = init_done_reg;
	assign output_on = op_reg;
	assign vout_setpoint = vout_reg;
	assign battery_functions = bf_reg[5:0];
	assign buffer_time = tbuf_reg;
	assign delay_time = tdly_reg;
	assign restart_time = trst_reg;

	AST_STATUS_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(txv_reg) && txd_reg[15:0] == CMD_SYSTEM_STATE
		|-> txd_reg[31:24] == 8'h00 && txd_reg[16] == 1'b0 && txd_reg[20:18] == 3'b000)
		else $error("status reply shows an unsupported bit");
	AST_INIT_TIME: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(init_done_reg) |-> $past(init_cnt_reg) == INIT_LAST)
		else $error("initialization ended at the wrong count");
	AST_ERR_SET: assert property (@(posedge clk) disable iff (!arst_n)
		nvm_fail |=> err_reg ##1 (err_reg || $past(nvm_done)))
		else $error("memory error flag not raised");
	AST_ERR_CLR: assert property (@(posedge clk) disable iff (!arst_n)
		nvm_done && !nvm_fail |=> !err_reg)
		else $error("memory error flag not cleared on success");
	AST_COMMIT_NOW: assert property (@(posedge clk) disable iff (!arst_n)
		// back-to-back changes may legally keep the pulse high
		change && policy == POLICY_NOW && !save_off
		|=> commit_reg ##1 (!commit_reg || $past(change)))
		else $error("immediate commit missing");
	AST_SAVE_OFF: assert property (@(posedge clk) disable iff (!arst_n)
		save_off && $past(save_off) |-> !commit_reg)
		else $error("commit while saving disabled");
	AST_QUIET_RESTART: assert property (@(posedge clk) disable iff (!arst_n)
		change && policy != POLICY_NOW |=> !commit_reg [*2])
		else $error("delayed commit not restarted by a change");
	AST_RSV_START: assert property (@(posedge clk) disable iff (!arst_n)
		hit && rx_dlc == DLC_WRITE && code == CMD_POWER_CONFIG
		&& wval[CFG_START_LSB +: 2] == START_RSV |=> $stable(cfg_reg[CFG_START_LSB +: 2]))
		else $error("reserved start-up encoding stored");
	AST_REPLY_FRAME: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(txv_reg) |-> txid_reg == (ID_TO_MASTER_BASE | {27'h0, addr_reg})
		&& txdlc_reg == ((txd_reg[15:0] == CMD_OPERATION) ? DLC_REPLY_BYTE : DLC_REPLY_WORD))
		else $error("reply identifier or length wrong");
	AST_WAKE_DROP: assert property (@(posedge clk) disable iff (!arst_n)
		wk_reg == WK_DROP |-> vout_target_pct == PCT_LOW ##1 vout_track_battery)
		else $error("wake-up does not drop then ramp");
	COV_READ: cover property (@(posedge clk) disable iff (!arst_n) $rose(txv_reg));
	COV_DELAYED: cover property (@(posedge clk) disable iff (!arst_n)
		pend_reg && q_exp && commit_next);
	COV_NO_BATTERY: cover property (@(posedge clk) disable iff (!arst_n) wk_reg == WK_HIGH);
	COV_TEST: cover property (@(posedge clk) disable iff (!arst_n) tp_reg && s_low);
endmodule // psu_can_status_config

//--- psu_can_status_config_tb_top.sv
`timescale 1ns/1ns
module psu_can_status_config_tb_top import psu_can_pkg::*;;
	localparam int TC = 4, Q1 = 4, Q10 = 8;
	logic clk = 1'b0, arst_n = 1'b0, e;
	logic [1:0] addr_strap = 2'b00;
	logic output_voltage_good = 1'b1, charge_or_battery_mode = 1'b0, battery_present = 1'b1;
	logic level_reached = 1'b0, vbat_ge_rated = 1'b1, charge_current_ok = 1'b1;
	logic battery_low = 1'b1, nvm_done = 1'b0, nvm_fail = 1'b0, prev_operation = 1'b0;
	logic rx_valid, rx_ready, tx_valid, tx_ready, init_done, output_on, vout_track_battery;
	logic charging_active, battery_test_pulse, battery_abnormal, nvm_commit;
	logic [28:0] rx_id, tx_id;
	logic [3:0] rx_dlc, tx_dlc;
	logic [31:0] rx_data, tx_data;
	logic [15:0] vout_setpoint, buffer_time, delay_time, restart_time, v, cfg;
	logic [5:0] battery_functions;
	logic [7:0] vout_target_pct;
	int n_errors = 0, samples_checked = 0, n_commit = 0, cycles = 0, n_low = 0, i, k, c0, q;
	psu_can_status_config #(.TICK_CYC(TC), .HOLD_MS(3), .WAKE_MS(20), .TEST_MS(5),
		.QUIET1_MS(Q1), .QUIET10_MS(Q10)) uut (.*);
	can_master_model m (.*);
	always #10 clk = ~clk;
	always @(posedge clk) if (nvm_commit === 1'b1) n_commit++;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checked %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask
	// reserved start or policy codes keep the old field; save bit 10 follows the write, other bits read zero
	function automatic logic [15:0] cfg_exp(input logic [15:0] o, input logic [15:0] w);
		logic [1:0] s;
		logic [1:0] p;
		s = (w[2:1] == START_RSV) ? o[2:1] : w[2:1];
		p = (w[9:8] == POLICY_RSV) ? o[9:8] : w[9:8];
		return {5'h00, w[10], p, 5'h00, s, 1'b0};
	endfunction
	task automatic wr(input logic [15:0] c, input logic [15:0] d);
		m.send(DLC_WRITE, c, d);
	endtask
	task automatic rd(input logic [15:0] c, input logic [15:0] x, input logic [3:0] l);
		int n0;
		n0 = m.got_n;
		m.send(DLC_READ, c, 16'h0000);
		for (k = 0; k < 50 && m.got_n == n0; k++) @(negedge clk);
		chk(m.got_n, n0 + 1);
		chk(m.got_data, {x, c});
		chk(m.got_dlc, l);
		chk(m.got_id, ID_TO_MASTER_BASE | {27'h0, addr_strap});
	endtask
	initial begin
		void'($urandom(32'h824B1CBA));
		addr_strap = 2'($urandom);
		repeat (5) @(negedge clk);
		arst_n = 1'b1;
		for (i = 0; i < 40 && init_done !== 1'b1; i++) @(negedge clk);
		chk(init_done, 1'b1);
		chk(vout_target_pct, PCT_RATED);
		chk(output_on, 1'b1);
		for (i = 0; i < 40 && vout_target_pct !== PCT_LOW; i++) @(negedge clk);
		chk(vout_target_pct, PCT_LOW);
		for (i = 0; i < 4 && vout_track_battery !== 1'b1; i++) @(negedge clk);
		chk(vout_track_battery, 1'b1);
		level_reached = 1'b1;
		for (i = 0; i < 8 && charging_active !== 1'b1; i++) @(negedge clk);
		chk(charging_active, 1'b1);
		rd(CMD_POWER_CONFIG, CFG_RESET, DLC_REPLY_WORD);
		rd(CMD_BAT_FUNC, BF_RESET, DLC_REPLY_WORD);
		rd(CMD_OPERATION, 16'h0001, DLC_REPLY_BYTE);
		for (i = 0; i < 150 && battery_test_pulse !== 1'b1; i++) @(negedge clk);
		chk(battery_test_pulse, 1'b1);
		repeat (2) @(negedge clk);
		chk(battery_abnormal, 1'b1);
		for (i = 0; i < 120 && vout_target_pct !== PCT_LOW; i++) @(negedge clk);
		chk(vout_target_pct, PCT_LOW);
		wr(CMD_BAT_FUNC, 16'h0000);
		repeat (200) @(negedge clk) if (vout_target_pct === PCT_LOW || battery_test_pulse !== 1'b0) n_low++;
		chk(n_low, 0);
		wr(CMD_BAT_FUNC, 16'hFFFF);
		rd(CMD_BAT_FUNC, BF_MASK, DLC_REPLY_WORD);
		chk(battery_functions, 6'h3F);
		v = 16'($urandom);
		wr(CMD_BUFFER_TIME, v);
		wr(CMD_DELAY_TIME, v ^ 16'hFFFF);
		wr(CMD_RESTART_TIME, v ^ 16'h5A5A);
		@(negedge clk);
		chk(buffer_time, v);
		chk(delay_time, v ^ 16'hFFFF);
		chk(restart_time, v ^ 16'h5A5A);
		for (i = 0; i < 6; i++) begin
			output_voltage_good = 1'($urandom);
			charge_or_battery_mode = 1'($urandom);
			e = 1'($urandom);
			nvm_fail = e;
			nvm_done = !e;
			@(negedge clk);
			nvm_fail = 1'b0;
			nvm_done = 1'b0;
			wr(CMD_SYSTEM_STATE, 16'hFFFF);
			repeat (4) @(negedge clk);
			rd(CMD_SYSTEM_STATE, {8'h00, charge_or_battery_mode, e, 1'b1, 3'b000,
				output_voltage_good, 1'b0}, DLC_REPLY_WORD);
		end
		wr(CMD_OPERATION, 16'h0000);
		wr(CMD_OPERATION, 16'h0002);
		@(negedge clk);
		chk(output_on, 1'b0);
		c0 = n_commit;
		wr(CMD_VOUT_SET, v);
		repeat (3) @(negedge clk);
		chk(n_commit, c0 + 1);
		chk(vout_setpoint, v);
		m.send(4'h3, CMD_VOUT_SET, v ^ 16'h00FF);
		rd(CMD_VOUT_SET, v, DLC_REPLY_WORD);
		cfg = CFG_RESET;
		for (i = 0; i < 8; i++) begin
			v = 16'($urandom);
			v[2:1] = 2'(i);
			v[9:8] = 2'(i >> 1);
			wr(CMD_POWER_CONFIG, v);
			cfg = cfg_exp(cfg, v);
			rd(CMD_POWER_CONFIG, cfg, DLC_REPLY_WORD);
		end
		for (i = 1; i < 3; i++) begin
			q = TC * ((i == 1) ? Q1 : Q10);
			wr(CMD_POWER_CONFIG, {6'h00, 2'(i), 8'h02});
			repeat (TC * Q10 * 2 + 10) @(negedge clk);
			c0 = n_commit;
			wr(CMD_VOUT_SET, v);
			repeat (q / 2) @(negedge clk);
			wr(CMD_VOUT_SET, v);
			repeat (q - 4) @(negedge clk);
			chk(n_commit, c0);
			repeat (30) @(negedge clk);
			chk(n_commit, c0 + 1);
		end
		wr(CMD_POWER_CONFIG, 16'h0402);
		repeat (3) @(negedge clk);
		c0 = n_commit;
		wr(CMD_VOUT_SET, v);
		repeat (TC * Q10 * 2) @(negedge clk);
		chk(n_commit, c0);
		close_out();
	end
endmodule // psu_can_status_config_tb_top
